// >>> core/dspma_block.sv
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Notes on behaviour
// - Simple mode passes products to outputs
// - Four 18x18 units form one 36x36
// - No input shift chain in 36x36
// - Pipeline register stages the 36x36 partial products
// - Accumulators fed by second and fourth units
// - Accumulator is 52 bits: 36 plus 16
// - Load and overflow act only when accumulating
// - Accumulator may subtract; overflow flags underflow too
// - Two-product sums or differences per pair
// - Complex product from one subtractor, one adder
// - Four-product sum from two first-stage results
// - Shift chains carry samples and coefficients
// - Shift chain cascades in and out
// - Counts hold for matched operand signedness
// - Eight 18-bit input and output units
// - Fourteen-line control bus for whole block
// - Control latency selectable zero, one, two
// - Sign select 1 means signed; full precision
// - Add/subtract select high adds, low subtracts
// - Load replaces running total with product
// - Overflow registered, not sticky
module dspma_block #(
  parameter dspma_pkg::dspma_mode_t MODE    = dspma_pkg::mode_simple,
  parameter bit                     NARROW  = 1'b0,
  parameter bit                     IN_REG  = 1'b1,
  parameter bit                     PIPE_REG = 1'b1,
  parameter bit                     SHIFT_A = 1'b0,
  parameter bit                     SHIFT_B = 1'b0
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Control bus
  input  wire logic        sign_a,
  input  wire logic        sign_b,
  input  wire logic        upper_add_or_subtract_sel,
  input  wire logic        lower_add_or_subtract_sel,
  input  wire logic [1:0]  accum_load,
  input  wire logic [3:0]  grp_enable,
  input  wire logic [3:0]  grp_clear,
  // Operand inputs
  input  wire logic [17:0] data_a1,
  input  wire logic [17:0] data_b1,
  input  wire logic [17:0] data_a2,
  input  wire logic [17:0] data_b2,
  input  wire logic [17:0] data_a3,
  input  wire logic [17:0] data_b3,
  input  wire logic [17:0] data_a4,
  input  wire logic [17:0] data_b4,
  // Shift chain cascade
  input  wire logic [17:0] chain_in_a,
  input  wire logic [17:0] chain_in_b,
  output logic      [17:0] chain_out_a,
  output logic      [17:0] chain_out_b,
  // Results
  output logic      [17:0] res_a,
  output logic      [17:0] res_b,
  output logic      [17:0] res_c,
  output logic      [17:0] res_d,
  output logic      [17:0] res_e,
  output logic      [17:0] res_f,
  output logic      [17:0] res_g,
  output logic      [17:0] res_h,
  output logic      [1:0]  overflow
);

  localparam int W  = dspma_pkg::WIDEW;
  localparam int NU = dspma_pkg::NUNITS;

  // Refuse configurations the datapath cannot serve
  generate
    if (MODE == dspma_pkg::mode_mul36 && (SHIFT_A || SHIFT_B)) begin : g_bad_chain
      $error("Shift chain input is not available with the 36x36 multiplier");
    end
    if ((SHIFT_A || SHIFT_B) && !IN_REG) begin : g_bad_inreg
      $error("Shift chain input needs the input registers");
    end
  endgenerate

  // Extend the low w bits of v to the working width
  function automatic logic [71:0] dspma_ext(input logic [71:0] v, input int w, input logic s);
    logic [71:0] r;
    r = v;
    for (int i = 0; i < 72; i++) begin
      if (i >= w) begin
        r[i] = s & v[w-1];
      end
    end
    return r;
  endfunction

  // Add when add is high, subtract when low
  function automatic logic [71:0] dspma_as(input logic [71:0] x, input logic [71:0] y, input logic add);
    return add ? x + y : x - y;
  endfunction

  // Reset release through two flip-flops
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // APB registers: control latency and status
  logic [1:0]  lat_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        ctrl_hit;
  logic        stat_hit;
  logic [1:0]  ovf_reg;
  assign ctrl_hit = (paddr == dspma_pkg::CTRL_OFS);
  assign stat_hit = (paddr == dspma_pkg::STATUS_OFS);

  // Answer is prepared in setup, so every access phase lasts one cycle
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= psel & ~penable & ~pready_reg;
      pslverr_reg <= psel & ~penable & ~(ctrl_hit | stat_hit);
      prdata_reg  <= 32'h0;
      if (psel && !penable && !pwrite && ctrl_hit) begin
        prdata_reg[dspma_pkg::LAT_LSB +: dspma_pkg::LAT_W] <= lat_reg;
      end else if (psel && !penable && !pwrite && stat_hit) begin
        prdata_reg[dspma_pkg::ST_OVF_LSB +: 2] <= ovf_reg;
        prdata_reg[dspma_pkg::ST_MODE_LSB +: 3] <= MODE;
        prdata_reg[dspma_pkg::ST_NARROW]  <= NARROW;
        prdata_reg[dspma_pkg::ST_SHIFT_A] <= SHIFT_A;
        prdata_reg[dspma_pkg::ST_SHIFT_B] <= SHIFT_B;
      end
    end
  end

  // Latency field written at the completing access edge
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      lat_reg <= dspma_pkg::LAT_RST;
    end else if (psel && penable && pready_reg && pwrite && ctrl_hit) begin
      lat_reg <= pwdata[dspma_pkg::LAT_LSB +: dspma_pkg::LAT_W];
    end
  end
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // Control delay stages, 14 control lines in all with enables and clears
  logic [dspma_pkg::NCTL-1:0] ctl_raw;
  logic [dspma_pkg::NCTL-1:0] ctl_d1_reg;
  logic [dspma_pkg::NCTL-1:0] ctl_d2_reg;
  logic [dspma_pkg::NCTL-1:0] ctl;
  assign ctl_raw = {accum_load, lower_add_or_subtract_sel, upper_add_or_subtract_sel,
                    sign_b, sign_a};
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctl_d1_reg <= '0;
      ctl_d2_reg <= '0;
    end else if (grp_clear[dspma_pkg::GRP_CTL]) begin
      ctl_d1_reg <= '0;
      ctl_d2_reg <= '0;
    end else if (grp_enable[dspma_pkg::GRP_CTL]) begin
      ctl_d1_reg <= ctl_raw;
      ctl_d2_reg <= ctl_d1_reg;
    end
  end
  // Latency three behaves as two
  assign ctl = (lat_reg == dspma_pkg::LAT_NONE) ? ctl_raw :
               (lat_reg == dspma_pkg::LAT_ONCE) ? ctl_d1_reg : ctl_d2_reg;

  logic sa;
  logic sb;
  logic rsgn;
  logic add_up;
  logic add_lo;
  assign sa     = ctl[dspma_pkg::CTL_SIGN_A];
  assign sb     = ctl[dspma_pkg::CTL_SIGN_B];
  assign rsgn   = sa | sb;
  assign add_up = ctl[dspma_pkg::CTL_ADD_UP];
  assign add_lo = ctl[dspma_pkg::CTL_ADD_LO];

  // Multiplier signs lead the adder controls by one stage at latency one and two; at latency zero both are undelayed
  logic msa;
  logic msb;
  assign msa = (lat_reg > dspma_pkg::LAT_ONCE) ? ctl_d1_reg[dspma_pkg::CTL_SIGN_A] : ctl_raw[dspma_pkg::CTL_SIGN_A];
  assign msb = (lat_reg > dspma_pkg::LAT_ONCE) ? ctl_d1_reg[dspma_pkg::CTL_SIGN_B] : ctl_raw[dspma_pkg::CTL_SIGN_B];

  // Input registers, each unit one 18x18 sub-block
  logic [17:0] a_raw [NU];
  logic [17:0] b_raw [NU];
  logic [17:0] a_q_reg [NU];
  logic [17:0] b_q_reg [NU];
  assign a_raw = '{data_a1, data_a2, data_a3, data_a4};
  assign b_raw = '{data_b1, data_b2, data_b3, data_b4};

  // Chains shift one unit per enabled edge; coefficients load in parallel when B is not chained
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      a_q_reg <= '{default: 18'h0};
      b_q_reg <= '{default: 18'h0};
    end else if (grp_clear[dspma_pkg::GRP_IN]) begin
      a_q_reg <= '{default: 18'h0};
      b_q_reg <= '{default: 18'h0};
    end else if (grp_enable[dspma_pkg::GRP_IN]) begin
      for (int u = 0; u < NU; u++) begin
        a_q_reg[u] <= !SHIFT_A ? a_raw[u] : (u == 0) ? chain_in_a : a_q_reg[u-1];
        b_q_reg[u] <= !SHIFT_B ? b_raw[u] : (u == 0) ? chain_in_b : b_q_reg[u-1];
      end
    end
  end
  assign chain_out_a = a_q_reg[NU-1];
  assign chain_out_b = b_q_reg[NU-1];

  // Operand routing; the 36x36 mode splits {a1,a2} and {b1,b2} into halves
  logic [17:0] a_op [NU];
  logic [17:0] b_op [NU];
  logic [NU-1:0] u_sa;
  logic [NU-1:0] u_sb;
  logic [35:0] p_raw [NU];
  logic [35:0] p_q_reg [NU];
  logic [35:0] p [NU];
  always_comb begin
    for (int u = 0; u < NU; u++) begin
      a_op[u] = IN_REG ? a_q_reg[u] : a_raw[u];
      b_op[u] = IN_REG ? b_q_reg[u] : b_raw[u];
      u_sa[u] = msa;
      u_sb[u] = msb;
    end
    if (MODE == dspma_pkg::mode_mul36) begin
      // Only upper halves carry the sign
      a_op[1] = a_op[0];
      a_op[3] = a_op[2];
      u_sa    = {1'b0, 1'b0, msa, msa};
      u_sb    = {1'b0, msb, 1'b0, msb};
      a_op[2] = IN_REG ? a_q_reg[1] : a_raw[1];
      a_op[3] = a_op[2];
      b_op[2] = b_op[0];
      b_op[3] = b_op[1];
      b_op[1] = IN_REG ? b_q_reg[1] : b_raw[1];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NU; g++) begin : g_unit
      dspma_mult_unit u_mult (
        .a      (a_op[g]),
        .b      (b_op[g]),
        .sign_a (u_sa[g]),
        .sign_b (u_sb[g]),
        .narrow (NARROW && MODE != dspma_pkg::mode_mul36),
        .prod   (p_raw[g])
      );
    end
  endgenerate

  // Pipeline register; in 36x36 mode it stages the partial products
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      p_q_reg <= '{default: 36'h0};
    end else if (grp_clear[dspma_pkg::GRP_PIPE]) begin
      p_q_reg <= '{default: 36'h0};
    end else if (grp_enable[dspma_pkg::GRP_PIPE]) begin
      p_q_reg <= p_raw;
    end
  end
  always_comb begin
    for (int u = 0; u < NU; u++) begin
      p[u] = PIPE_REG ? p_q_reg[u] : p_raw[u];
    end
  end

  // Wide product views, extended by result signedness
  logic [71:0] pw [NU];
  logic [71:0] pl [NU];
  logic [71:0] ph [NU];
  always_comb begin
    for (int u = 0; u < NU; u++) begin
      pw[u] = dspma_ext({36'h0, p[u]}, dspma_pkg::PRODW, rsgn);
      pl[u] = dspma_ext({54'h0, p[u][17:0]}, dspma_pkg::NPRODW, rsgn);
      ph[u] = dspma_ext({54'h0, p[u][35:18]}, dspma_pkg::NPRODW, rsgn);
    end
  end

  // Accumulators live in the output register, second and fourth units feed them
  logic [143:0] out_reg;
  logic [71:0]  acc_cur [2];
  logic [71:0]  acc_in  [2];
  logic [71:0]  acc_sum [2];
  logic [51:0]  acc_next [2];
  logic [1:0]   acc_ovf;
  logic [1:0]   acc_add;
  always_comb begin
    acc_add = {add_lo, add_up};
    for (int k = 0; k < 2; k++) begin
      acc_cur[k] = dspma_ext({20'h0, out_reg[k*W +: dspma_pkg::ACCW]}, dspma_pkg::ACCW, rsgn);
      acc_in[k]  = NARROW ? pl[2*k+1] : pw[2*k+1];
      acc_sum[k] = dspma_as(acc_cur[k], acc_in[k], acc_add[k]);
      // Load replaces the total with the product
      acc_next[k] = ctl[dspma_pkg::CTL_LOAD0 + k] ? acc_in[k][51:0] : acc_sum[k][51:0];
      // Signed: bit 52 differs from 51; unsigned: carry or borrow in bit 52
      acc_ovf[k] = ~ctl[dspma_pkg::CTL_LOAD0 + k] &
                   (rsgn ? (acc_sum[k][52] ^ acc_sum[k][51]) : acc_sum[k][52]);
    end
  end

  // First and second stage sums
  logic [71:0] s_up;
  logic [71:0] s_lo;
  logic [71:0] n_up_lo;
  logic [71:0] n_up_hi;
  logic [71:0] n_lo_lo;
  logic [71:0] n_lo_hi;
  logic [71:0] mul36;
  logic [143:0] res;
  always_comb begin
    s_up    = dspma_as(pw[0], pw[1], add_up);
    s_lo    = dspma_as(pw[2], pw[3], add_lo);
    n_up_lo = dspma_as(pl[0], pl[1], add_up);
    n_up_hi = dspma_as(ph[0], ph[1], add_up);
    n_lo_lo = dspma_as(pl[2], pl[3], add_lo);
    n_lo_hi = dspma_as(ph[2], ph[3], add_lo);
    // hh<<36 + (hl+lh)<<18 + ll; low partial is unsigned
    mul36 = (pw[0] << 36) + ((dspma_ext({36'h0, p[1]}, dspma_pkg::PRODW, sa) +
             dspma_ext({36'h0, p[2]}, dspma_pkg::PRODW, sb)) << 18) + {36'h0, p[3]};
    res   = '0;
    case (MODE)
      dspma_pkg::mode_simple: res = {p[3], p[2], p[1], p[0]};
      dspma_pkg::mode_mac: res = {dspma_ext({20'h0, acc_next[1]}, dspma_pkg::ACCW, rsgn),
                                  dspma_ext({20'h0, acc_next[0]}, dspma_pkg::ACCW, rsgn)};
      dspma_pkg::mode_add2: begin
        if (NARROW) begin
          res = {n_lo_hi[35:0], n_lo_lo[35:0], n_up_hi[35:0], n_up_lo[35:0]};
        end else begin
          res = {s_lo, s_up};
        end
      end
      dspma_pkg::mode_add4: begin
        if (NARROW) begin
          res = {n_up_hi + n_lo_hi, n_up_lo + n_lo_lo};
        end else begin
          res = {{72{rsgn & s_up[71]}}, s_up + s_lo};
        end
      end
      dspma_pkg::mode_mul36: res = {{72{rsgn & mul36[71]}}, mul36};
      default: res = '0;
    endcase
  end

  // Output registers, always present so every result comes from a flop
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      out_reg <= '0;
    end else if (grp_clear[dspma_pkg::GRP_OUT]) begin
      out_reg <= '0;
    end else if (grp_enable[dspma_pkg::GRP_OUT]) begin
      out_reg <= res;
    end
  end

  // Overflow follows each enabled accumulate step, holds while disabled, zero outside accumulator mode
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ovf_reg <= 2'h0;
    end else if (grp_clear[dspma_pkg::GRP_OUT]) begin
      ovf_reg <= 2'h0;
    end else if (grp_enable[dspma_pkg::GRP_OUT]) begin
      ovf_reg <= (MODE == dspma_pkg::mode_mac) ? acc_ovf : 2'h0;
    end
  end
  assign overflow = ovf_reg;

  assign res_a = out_reg[0 +: 18];
  assign res_b = out_reg[18 +: 18];
  assign res_c = out_reg[36 +: 18];
  assign res_d = out_reg[54 +: 18];
  assign res_e = out_reg[72 +: 18];
  assign res_f = out_reg[90 +: 18];
  assign res_g = out_reg[108 +: 18];
  assign res_h = out_reg[126 +: 18];

endmodule

// >>> core/dspma_mult_unit.sv
`timescale 1ns/1ps
// One 18x18 multiplier sub-block, or two 9x9 multipliers when narrow
module dspma_mult_unit (
  // Operands and signedness
  input  wire logic [17:0] a,
  input  wire logic [17:0] b,
  input  wire logic        sign_a,
  input  wire logic        sign_b,
  input  wire logic        narrow,
  // Product, two packed 18-bit products when narrow
  output logic      [35:0] prod
);

  // Full precision product of two 18-bit operands with sign control
  function automatic logic [35:0] dspma_mul18(input logic [17:0] x, input logic [17:0] y,
                                              input logic sx, input logic sy);
    logic signed [18:0] ex;
    logic signed [18:0] ey;
    logic signed [37:0] pr;
    ex = {sx & x[17], x};
    ey = {sy & y[17], y};
    pr = ex * ey;
    return pr[35:0];
  endfunction

  logic [17:0] a_lo;
  logic [17:0] b_lo;
  logic [17:0] a_hi;
  logic [17:0] b_hi;
  logic [35:0] p_lo;
  logic [35:0] p_hi;

  // Narrow operands are extended so one function serves both sizes
  assign a_lo = {{9{sign_a & a[8]}}, a[8:0]};
  assign b_lo = {{9{sign_b & b[8]}}, b[8:0]};
  assign a_hi = {{9{sign_a & a[17]}}, a[17:9]};
  assign b_hi = {{9{sign_b & b[17]}}, b[17:9]};
  assign p_lo = dspma_mul18(a_lo, b_lo, sign_a, sign_b);
  assign p_hi = dspma_mul18(a_hi, b_hi, sign_a, sign_b);
  assign prod = narrow ? {p_hi[17:0], p_lo[17:0]} : dspma_mul18(a, b, sign_a, sign_b);

endmodule

// >>> core/dspma_pkg.sv
package dspma_pkg;

  // Operating modes, fixed per block instance
  typedef enum logic [2:0] {
    mode_simple,
    mode_mac,
    mode_add2,
    mode_add4,
    mode_mul36
  } dspma_mode_t;

  // Datapath widths
  localparam int OPW    = 18;         // Operand width of one unit
  localparam int HALFW  = 9;          // Narrow operand width
  localparam int PRODW  = 36;         // Full 18x18 product width
  localparam int NPRODW = 18;         // Narrow 9x9 product width
  localparam int HEADW  = 16;         // Accumulation headroom
  localparam int ACCW   = PRODW + HEADW;  // Accumulator width, 52
  localparam int NUNITS = 4;          // 18x18 multiplier sub-blocks
  localparam int RESW   = 144;        // Eight 18-bit result ports
  localparam int WIDEW  = 72;         // Working width of sums
  localparam int NCTL   = 6;          // Delayed control lines

  // Control line positions in the delayed control vector
  localparam int CTL_SIGN_A = 0;
  localparam int CTL_SIGN_B = 1;
  localparam int CTL_ADD_UP = 2;
  localparam int CTL_ADD_LO = 3;
  localparam int CTL_LOAD0  = 4;
  localparam int CTL_LOAD1  = 5;

  // Control enable and clear group assignment
  localparam int GRP_IN   = 0;        // Input registers
  localparam int GRP_PIPE = 1;        // Pipeline register
  localparam int GRP_OUT  = 2;        // Output registers and accumulators
  localparam int GRP_CTL  = 3;        // Control delay stages

  // Register map
  localparam int          AW          = 8;
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  STATUS_OFS  = 8'h04;
  localparam int          LAT_LSB     = 0;
  localparam int          LAT_W       = 2;
  localparam logic [1:0]  LAT_RST     = 2'h0;
  localparam logic [1:0]  LAT_NONE    = 2'h0;
  localparam logic [1:0]  LAT_ONCE    = 2'h1;
  localparam int          ST_OVF_LSB  = 0;
  localparam int          ST_MODE_LSB = 4;
  localparam int          ST_NARROW   = 8;
  localparam int          ST_SHIFT_A  = 9;
  localparam int          ST_SHIFT_B  = 10;

endpackage

// >>> sim/dspma_block_chk.sv
`timescale 1ns/1ps
// Port-level checks of the multiply-add block, bound to every instance
module dspma_block_chk #(
  parameter dspma_pkg::dspma_mode_t MODE    = dspma_pkg::mode_simple,
  parameter bit                     NARROW  = 1'b0,
  parameter bit                     IN_REG  = 1'b1,
  parameter bit                     SHIFT_A = 1'b0
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Register bus
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Controls, operands and results
  input wire logic [1:0]  accum_load,
  input wire logic [3:0]  grp_enable,
  input wire logic [3:0]  grp_clear,
  input wire logic [17:0] data_a4,
  input wire logic [17:0] chain_out_a,
  input wire logic [17:0] res_a,
  input wire logic [17:0] res_b,
  input wire logic [17:0] res_c,
  input wire logic [1:0]  overflow
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Copy of the latency field; the load check is only valid when controls align with data
  logic [1:0] lat_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lat_reg <= 2'h0;
    end else if (psel && penable && pready && pwrite && paddr == dspma_pkg::CTRL_OFS) begin
      lat_reg <= pwdata[1:0];
    end
  end

  property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("ready not a single pulse after setup");
  property p_bad; pready && paddr != dspma_pkg::CTRL_OFS && paddr != dspma_pkg::STATUS_OFS |-> pslverr && prdata == 0;
  endproperty
  a_bad: assert property (p_bad) else $error("unmapped access not refused");
  property p_stat; pready && !pwrite && paddr == dspma_pkg::STATUS_OFS |-> prdata[6:4] == 3'(MODE) && prdata[8] == NARROW;
  endproperty
  a_stat: assert property (p_stat) else $error("status shows wrong configuration");
  property p_res_hold; !grp_enable[2] && !grp_clear[2] |=> $stable({res_c, res_b, res_a}); endproperty
  a_res_hold: assert property (p_res_hold) else $error("result moved while disabled");
  property p_ovf_hold; !grp_enable[2] && !grp_clear[2] |=> $stable(overflow); endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow not a register");
  property p_clr; grp_clear[2] |=> {res_c, res_b, res_a} == 0 && overflow == 2'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear did not empty the output stage");
  property p_chain; !SHIFT_A && IN_REG && $past(resetn, 3) && grp_enable[0] && !grp_clear[0]
    |=> chain_out_a == $past(data_a4); endproperty
  a_chain: assert property (p_chain) else $error("chain output not the captured operand");
  property p_ld_ovf; (MODE == dspma_pkg::mode_mac && accum_load[0] && lat_reg == 2'h2)
    ##0 (grp_enable == 4'hf && grp_clear == 4'h0)[*4] |-> !overflow[0]; endproperty
  a_ld_ovf: assert property (p_ld_ovf) else $error("overflow raised by a load");
endmodule

bind dspma_block dspma_block_chk #(.MODE(MODE), .NARROW(NARROW), .IN_REG(IN_REG), .SHIFT_A(SHIFT_A)) i_chk (
  .clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .accum_load(accum_load),
  .grp_enable(grp_enable), .grp_clear(grp_clear), .data_a4(data_a4), .chain_out_a(chain_out_a),
  .res_a(res_a), .res_b(res_b), .res_c(res_c), .overflow(overflow));

// >>> sim/dspma_block_tb_top.sv
`timescale 1ns/1ps
module dspma_block_tb_top;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, sgn, ups, los, hold;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [17:0] a2, b2, a4, b4, junk, coa, cob, res_a, res_b, res_c, res_d, res_e, res_f, res_g, res_h;
  logic [1:0]  ld, overflow, ovf_seen;
  logic [3:0]  ena, clr;
  logic [51:0] exp0, exp1;
  int          err_count, samples_checked, cyc;

  dspma_fabric i_fab (.clk(clk), .resetn(resetn), .overflow(overflow), .a2(a2), .b2(b2), .a4(a4), .b4(b4),
    .junk(junk), .sgn(sgn), .ups(ups), .los(los), .ld(ld), .ena(ena), .clr(clr), .ovf_seen(ovf_seen));

  dspma_block #(.MODE(dspma_pkg::mode_mac)) i_dut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sign_a(sgn), .sign_b(sgn), .upper_add_or_subtract_sel(ups), .lower_add_or_subtract_sel(los),
    .accum_load(ld), .grp_enable(ena), .grp_clear(clr), .data_a1(junk), .data_b1(~junk), .data_a2(a2),
    .data_b2(b2), .data_a3(~junk), .data_b3(junk), .data_a4(a4), .data_b4(b4), .chain_in_a(junk),
    .chain_in_b(~junk), .chain_out_a(coa), .chain_out_b(cob), .res_a(res_a), .res_b(res_b), .res_c(res_c),
    .res_d(res_d), .res_e(res_e), .res_f(res_f), .res_g(res_g), .res_h(res_h), .overflow(overflow));

  always #12.5 clk = ~clk;

  // Hang guard, far above the fewer than a hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [63:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task report_and_stop;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One APB transfer; request held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, ad, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  // Next accumulator value, one bit wider to expose carry or borrow
  function automatic logic [52:0] nxt(input logic [51:0] acc, input logic [17:0] a, b, input logic l, ad, s);
    logic signed [52:0] p;
    logic [52:0]        base;
    if (s) p = $signed(a) * $signed(b);
    else p = a * b;
    base = l ? 53'h0 : (s ? {acc[51], acc} : {1'b0, acc});
    return (l || ad) ? base + p : base - p;
  endfunction

  // One operation on both accumulators, then zero operands to let it settle
  task automatic mac_op(input logic [17:0] a, b, c, d, input logic [1:0] l, input logic u, o, s);
    logic [52:0] e0, e1;
    logic [1:0]  ov;
    e0 = nxt(exp0, a, b, l[0], u, s);
    e1 = nxt(exp1, c, d, l[1], o, s);
    ov = {~l[1] & (s ? e1[52] ^ e1[51] : e1[52]), ~l[0] & (s ? e0[52] ^ e0[51] : e0[52])};
    if (hold) {e0, e1, ov} = {1'b0, exp0, 1'b0, exp1, 2'h0};
    @(posedge clk);
    i_fab.drive(a, b, c, d, l, u, o, s);
    @(posedge clk);
    i_fab.drive(18'h0, 18'h0, 18'h0, 18'h0, 2'h0, 1'b1, 1'b1, s);
    #1 chk(64'({cob, coa}), 64'({d, c}));
    repeat (2) @(posedge clk);
    #1 chk(64'({res_c[15:0], res_b, res_a}), 64'(e0[51:0]));
    chk(64'({res_g[15:0], res_f, res_e}), 64'(e1[51:0]));
    chk(64'(overflow), 64'(ov));
    chk(64'({res_h, res_g[17:16], res_d, res_c[17:16]}), 64'({{20{s & e1[51]}}, {20{s & e0[51]}}}));
    @(posedge clk);
    #1 chk(64'(overflow), 64'h0);
    exp0 = e0[51:0];
    exp1 = e1[51:0];
  endtask

  task automatic t_regs;
    logic [31:0] rd;
    logic        er;
    apb(1'b0, dspma_pkg::CTRL_OFS, 32'h0, rd, er);
    chk(64'(rd), 64'(dspma_pkg::LAT_RST));
    apb(1'b1, dspma_pkg::CTRL_OFS, 32'h2, rd, er);
    apb(1'b0, dspma_pkg::CTRL_OFS, 32'h0, rd, er);
    chk(64'(rd), 64'h2);
    apb(1'b0, dspma_pkg::STATUS_OFS, 32'h0, rd, er);
    chk(64'(rd & 32'h770), 64'h10);
    apb(1'b0, 8'h08, 32'hffff_ffff, rd, er);
    chk(64'({er, rd}), 64'h1_0000_0000);
  endtask

  // Load, add, independent subtract, widest product, unsigned borrow
  task automatic t_mac;
    mac_op(18'h3, 18'h5, 18'h100, 18'h3, 2'h3, 1'b1, 1'b1, 1'b0);
    mac_op(18'h7, 18'h2, 18'h5, 18'h5, 2'h0, 1'b1, 1'b0, 1'b0);
    mac_op(18'h1, 18'h1, 18'h3ffff, 18'h3ffff, 2'h1, 1'b0, 1'b1, 1'b0);
    mac_op(18'h2, 18'h1, 18'h0, 18'h0, 2'h0, 1'b0, 1'b1, 1'b0);
    chk(64'(ovf_seen), 64'h1);
  endtask

  // Output stage frozen by its enable, then emptied by its clear
  task automatic t_hold_clear;
    @(posedge clk);
    i_fab.ena <= 4'hb;
    hold = 1'b1;
    mac_op(18'h9, 18'h9, 18'h9, 18'h9, 2'h0, 1'b1, 1'b1, 1'b0);
    hold = 1'b0;
    @(posedge clk);
    i_fab.ena <= 4'hf;
    i_fab.clr <= 4'h4;
    @(posedge clk);
    i_fab.clr <= 4'h0;
    #1 chk(64'({res_c, res_b, res_a}), 64'h0);
    exp0 = '0;
    exp1 = '0;
  endtask

  // Signed operands, negative load then signed subtract
  task automatic t_signed;
    mac_op(18'h3fffd, 18'h5, 18'h3fffd, 18'h3fffd, 2'h3, 1'b1, 1'b1, 1'b1);
    mac_op(18'h2, 18'h3, 18'h3ffff, 18'h1, 2'h0, 1'b0, 1'b1, 1'b1);
  endtask

  initial begin
    {clk, resetn, psel, penable, pwrite, paddr, pwdata, hold} = '0;
    {exp0, exp1} = '0;
    {err_count, samples_checked, cyc} = '0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    t_regs();
    t_mac();
    t_hold_clear();
    t_signed();
    report_and_stop();
  end
endmodule

// >>> sim/dspma_fabric.sv
`timescale 1ns/1ps
// Surrounding fabric: drives operands and controls, keeps a held overflow
module dspma_fabric (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Status from the block
  input  wire logic [1:0]  overflow,
  // Operands and controls toward the block
  output logic      [17:0] a2,
  output logic      [17:0] b2,
  output logic      [17:0] a4,
  output logic      [17:0] b4,
  output logic      [17:0] junk,
  output logic             sgn,
  output logic             ups,
  output logic             los,
  output logic      [1:0]  ld,
  output logic      [3:0]  ena,
  output logic      [3:0]  clr,
  output logic      [1:0]  ovf_seen
);
  // Idle values at time zero
  initial begin
    {a2, b2, a4, b4, junk, sgn, ld, clr} = '0;
    {ups, los, ena} = 6'h3f;
  end

  // Unused lanes see a moving pattern, so any leak into the sums shows up
  always @(posedge clk) begin
    junk <= junk + 18'h0b3d5;
  end

  // The flag is a pulse; fabric keeps a sticky copy where one is wanted
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ovf_seen <= 2'h0;
    end else begin
      ovf_seen <= ovf_seen | overflow;
    end
  end

  // One operand set per call, changed just after an edge
  task drive(input logic [17:0] pa, pb, pc, pd, input logic [1:0] pl, input logic pu, po, ps);
    a2 <= pa;
    b2 <= pb;
    a4 <= pc;
    b4 <= pd;
    ld <= pl;
    ups <= pu;
    los <= po;
    sgn <= ps;
  endtask
endmodule
